/* rtl/ftt_pkg.sv */
package ftt_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int COUNT_W = 16;
   localparam int IRQ_W = 3;

   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_T2_COUNT_LOW = 8'h1D;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h1E;
   localparam logic [ADDR_W-1:0] ADDR_RELOAD_HIGH = 8'h1F;
   localparam logic [ADDR_W-1:0] ADDR_RELOAD_LOW = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 8'h21;
   localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 8'h22;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h30;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h31;
   localparam logic [ADDR_W-1:0] ADDR_RUN_STATE = 8'h32;

   // Control field layout
   localparam int CTRL_STOP_RX_BIT = 7;
   localparam int CTRL_START_LSB = 4;
   localparam int CTRL_AUTO_BIT = 3;
   localparam int CTRL_CLK_LSB = 0;

   // Interrupt status bits
   localparam int IRQ_UNDERFLOW_BIT = 0;
   localparam int IRQ_RX_STOP_BIT = 1;
   localparam int IRQ_TRIM_DONE_BIT = 2;

   // Run state readback bits
   localparam int RUN_BIT = 0;
   localparam int ARMED_BIT = 1;

   localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;

   // Start modes
   typedef enum logic [1:0] {
      START_NONE = 2'h0,
      START_AFTER_TX = 2'h1,
      START_TRIM_NO_UF = 2'h2,
      START_TRIM_UF = 2'h3
   } ftt_start_t;

   // Counting clock sources
   typedef enum logic [1:0] {
      CLK_CARRIER = 2'h0,
      CLK_SUBCARRIER = 2'h1,
      CLK_TIMER0 = 2'h2,
      CLK_TIMER1 = 2'h3
   } ftt_clk_sel_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ARMED = 2'h1,
      ST_RUN = 2'h3
   } ftt_state_t;

   // Clock rates and derived dividers
   localparam longint CLK_HZ = 50000000;
   localparam longint CARRIER_HZ = 13560000;
   localparam int ACC_W = 32;
   localparam logic [ACC_W-1:0] CARRIER_STEP = ACC_W'((CARRIER_HZ << ACC_W) / CLK_HZ);
   localparam int SUB_DIV_W = 6;
   localparam logic [SUB_DIV_W-1:0] SUB_DIV_LAST = 6'h3F;
endpackage

/* rtl/ftt_timer.sv */
`timescale 1ns/10ps
module ftt_timer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ftt_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ftt_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ftt_pkg::DATA_W-1:0] reg_rdata,
   input wire logic tx_end,
   input wire logic rx_first_nibble,
   input wire logic timer0_underflow,
   input wire logic timer1_underflow,
   input wire logic lfo_rise,
   input wire logic start_now,
   input wire logic stop_now,
   input wire logic [ftt_pkg::COUNT_W-1:0] second_timer_count,
   output logic timer_underflow_request,
   output logic timer_running,
   output logic irq
);
   import ftt_pkg::*;

   logic rst_meta;
   logic rst_n;
   logic stop_on_receive;
   ftt_start_t start_mode_select;
   logic auto_reload_enable;
   ftt_clk_sel_t count_clock_select;
   logic [DATA_W-1:0] reload_high_byte;
   logic [DATA_W-1:0] reload_low_byte;
   logic [COUNT_W-1:0] reload_word;
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] next_count;
   ftt_state_t state;
   ftt_state_t next_state;
   logic [ACC_W-1:0] carrier_acc;
   logic carrier_tick;
   logic [SUB_DIV_W-1:0] sub_cnt;
   logic sub_tick;
   logic tick;
   logic trim_mode;
   logic trim_edge;
   logic rx_halt;
   logic underflow_evt;
   logic trim_done_evt;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_events;
   logic [IRQ_W-1:0] irq_clear;
   logic quiet;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and reload registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_on_receive <= 1'b0;
         start_mode_select <= START_NONE;
         auto_reload_enable <= 1'b0;
         count_clock_select <= CLK_CARRIER;
      end else if (reg_wr && reg_addr == ADDR_CONTROL) begin
         stop_on_receive <= reg_wdata[CTRL_STOP_RX_BIT];
         start_mode_select <= ftt_start_t'(reg_wdata[CTRL_START_LSB +: 2]);
         auto_reload_enable <= reg_wdata[CTRL_AUTO_BIT];
         count_clock_select <= ftt_clk_sel_t'(reg_wdata[CTRL_CLK_LSB +: 2]);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_high_byte <= '0;
         reload_low_byte <= '0;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_RELOAD_HIGH) begin
            reload_high_byte <= reg_wdata;
         end
         if (reg_addr == ADDR_RELOAD_LOW) begin
            reload_low_byte <= reg_wdata;
         end
      end
   end

   assign reload_word = {reload_high_byte, reload_low_byte};

   ////////////////////////////////////////////////////////////////////////////
   // Counting clock enables
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_acc <= '0;
         carrier_tick <= 1'b0;
      end else begin
         {carrier_tick, carrier_acc} <= {1'b0, carrier_acc} + {1'b0, CARRIER_STEP};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sub_cnt <= '0;
         sub_tick <= 1'b0;
      end else begin
         sub_tick <= carrier_tick && sub_cnt == SUB_DIV_LAST;
         if (carrier_tick) begin
            sub_cnt <= sub_cnt + 6'h01;
         end
      end
   end

   always_comb begin
      unique case (count_clock_select)
         CLK_CARRIER: tick = carrier_tick;
         CLK_SUBCARRIER: tick = sub_tick;
         CLK_TIMER0: tick = timer0_underflow;
         CLK_TIMER1: tick = timer1_underflow;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter sequencing
   assign trim_mode = start_mode_select[1];
   assign trim_edge = trim_mode && lfo_rise;
   assign rx_halt = stop_on_receive && !trim_mode && rx_first_nibble && state == ST_RUN;
   assign quiet = !stop_now && !rx_halt && !trim_edge && !start_now;

   always_comb begin
      next_state = state;
      next_count = count;
      underflow_evt = 1'b0;
      trim_done_evt = 1'b0;
      if (stop_now || rx_halt) begin
         next_state = ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_now && trim_mode) begin
                  next_state = ST_ARMED;
               end else if (start_now || (start_mode_select == START_AFTER_TX && tx_end)) begin
                  next_state = ST_RUN;
                  next_count = reload_word;
               end
            end
            ST_ARMED: begin
               if (!trim_mode) begin
                  next_state = ST_IDLE;
               end else if (trim_edge) begin
                  next_state = ST_RUN;
                  next_count = reload_word;
               end
            end
            ST_RUN: begin
               if (trim_edge) begin
                  next_state = ST_IDLE;
                  trim_done_evt = 1'b1;
               end else if (tick) begin
                  if (count != COUNT_ZERO) begin
                     next_count = count - COUNT_ONE;
                  end else if (start_mode_select != START_TRIM_NO_UF) begin
                     underflow_evt = 1'b1;
                     if (auto_reload_enable) begin
                        next_count = reload_word;
                     end else begin
                        next_state = ST_IDLE;
                     end
                  end
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         count <= COUNT_ZERO;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_underflow_request <= 1'b0;
         timer_running <= 1'b0;
      end else begin
         timer_underflow_request <= underflow_evt;
         timer_running <= next_state == ST_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and output
   always_comb begin
      irq_events = '0;
      irq_events[IRQ_UNDERFLOW_BIT] = underflow_evt;
      irq_events[IRQ_RX_STOP_BIT] = rx_halt;
      irq_events[IRQ_TRIM_DONE_BIT] = trim_done_evt;
      irq_clear = '0;
      if (reg_wr && reg_addr == ADDR_IRQ_STATUS) begin
         irq_clear = reg_wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_events;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= '0;
      end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
         irq_mask <= reg_wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= RDATA_NONE;
      end else if (reg_rd) begin
         reg_rdata <= RDATA_NONE;
         case (reg_addr)
            ADDR_CONTROL: begin
               reg_rdata[CTRL_STOP_RX_BIT] <= stop_on_receive;
               reg_rdata[CTRL_START_LSB +: 2] <= start_mode_select;
               reg_rdata[CTRL_AUTO_BIT] <= auto_reload_enable;
               reg_rdata[CTRL_CLK_LSB +: 2] <= count_clock_select;
            end
            ADDR_RELOAD_HIGH: reg_rdata <= reload_high_byte;
            ADDR_RELOAD_LOW: reg_rdata <= reload_low_byte;
            ADDR_COUNT_HIGH: reg_rdata <= count[COUNT_W-1:DATA_W];
            ADDR_COUNT_LOW: reg_rdata <= count[DATA_W-1:0];
            ADDR_T2_COUNT_LOW: reg_rdata <= second_timer_count[DATA_W-1:0];
            ADDR_IRQ_STATUS: reg_rdata[IRQ_W-1:0] <= irq_status;
            ADDR_IRQ_MASK: reg_rdata[IRQ_W-1:0] <= irq_mask;
            ADDR_RUN_STATE: begin
               reg_rdata[RUN_BIT] <= state == ST_RUN;
               reg_rdata[ARMED_BIT] <= state == ST_ARMED;
            end
            default: reg_rdata <= RDATA_NONE;
         endcase
      end else begin
         reg_rdata <= RDATA_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_rx_halt_stops: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == ST_RUN && stop_on_receive && !trim_mode && rx_first_nibble
      |=> state == ST_IDLE && !timer_running)
      else $error("receive did not halt timer");

   chk_trim_ignores_rx: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == ST_RUN && trim_mode && rx_first_nibble && !stop_now && !lfo_rise
      && !(tick && count == COUNT_ZERO && !auto_reload_enable)
      |=> state == ST_RUN)
      else $error("trimming run halted by receive");

   chk_auto_start_tx: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == ST_IDLE && start_mode_select == START_AFTER_TX && tx_end && !stop_now
      |=> state == ST_RUN && count == $past(reload_word))
      else $error("no automatic start after transmit");

   chk_no_auto_start: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == ST_IDLE && start_mode_select == START_NONE && !start_now
      |=> state == ST_IDLE)
      else $error("timer started without request");

   chk_trim_window: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == ST_ARMED && trim_edge && !stop_now
      |=> state == ST_RUN ##0 (!lfo_rise && !stop_now)[*2] |=> state == ST_RUN)
      else $error("trimming window not opened on edge");

   chk_reload_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == ST_RUN && quiet && tick && count == COUNT_ZERO && auto_reload_enable
      && start_mode_select != START_TRIM_NO_UF
      |=> state == ST_RUN && count == $past(reload_word) && timer_underflow_request)
      else $error("auto reload failed at zero");

   chk_stop_at_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == ST_RUN && quiet && tick && count == COUNT_ZERO && !auto_reload_enable
      && start_mode_select != START_TRIM_NO_UF
      |=> state == ST_IDLE ##1 !timer_underflow_request)
      else $error("timer did not stop at zero");

   chk_underflow_flag: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(timer_underflow_request) |-> irq_status[IRQ_UNDERFLOW_BIT])
      else $error("underflow flag not set");

   chk_count_step: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == ST_RUN && quiet && count != COUNT_ZERO
      |=> count == $past(count) - ($past(tick) ? COUNT_ONE : COUNT_ZERO))
      else $error("count step mismatch");

   chk_count_readback: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == ADDR_COUNT_HIGH |=> reg_rdata == $past(count[COUNT_W-1:DATA_W]))
      else $error("count high byte readback wrong");

   chk_reserved_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata[6] == 1'b0 && reg_rdata[2] == 1'b0)
      else $error("reserved control bits not zero");

   chk_second_low: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == ADDR_T2_COUNT_LOW
      |=> reg_rdata == $past(second_timer_count[DATA_W-1:0]))
      else $error("second timer low byte wrong");
endmodule

/* tb/test_frontend_timer_three.sv */
`timescale 1ns/10ps
module test_frontend_timer_three;
   import ftt_pkg::*;
   logic clk;
   logic rstn;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic tx_end;
   logic rx_first_nibble;
   logic timer0_underflow;
   logic timer1_underflow;
   logic lfo_rise;
   logic start_now;
   logic stop_now;
   logic [COUNT_W-1:0] second_timer_count;
   logic timer_underflow_request;
   logic timer_running;
   logic irq;
   int n_fail;
   int check_count;
   int cycles;
   logic [31:0] seed;
   logic [31:0] v;
   logic [7:0] d;
   int m_cnt;
   int m_rel;
   int m_new;
   int m_auto;
   int m_run;
   int m_nouf;

   ftt_timer dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_end(tx_end),
      .rx_first_nibble(rx_first_nibble), .timer0_underflow(timer0_underflow),
      .timer1_underflow(timer1_underflow), .lfo_rise(lfo_rise), .start_now(start_now),
      .stop_now(stop_now), .second_timer_count(second_timer_count),
      .timer_underflow_request(timer_underflow_request), .timer_running(timer_running),
      .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task print_verdict;
      $display("mismatches=%0d comparisons=%0d", n_fail, check_count);
      if (n_fail == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Hang guard, run needs about 1400 cycles
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 10000) begin
         n_fail = n_fail + 1;
         $display("[ERR] t=%0t timeout got=%h exp=%h", $time, cycles, 10000);
         print_verdict();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [15:0] got, input logic [15:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] x);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 x = reg_rdata;
   endtask

   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      rd(a, d);
      check({8'h00, d}, {8'h00, e});
   endtask

   task chk_cnt;
      logic [7:0] h;
      logic [7:0] l;
      rd(ADDR_COUNT_HIGH, h);
      rd(ADDR_COUNT_LOW, l);
      check({h, l}, m_cnt[15:0]);
   endtask

   // Event codes: start, stop, tx end, rx nibble, timer0, timer1, lfo edge
   task ev(input int k);
      @(posedge clk);
      case (k)
         0: start_now <= 1'b1;
         1: stop_now <= 1'b1;
         2: tx_end <= 1'b1;
         3: rx_first_nibble <= 1'b1;
         4: timer0_underflow <= 1'b1;
         5: timer1_underflow <= 1'b1;
         default: lfo_rise <= 1'b1;
      endcase
      @(posedge clk);
      {start_now, stop_now, tx_end, rx_first_nibble} <= 4'h0;
      {timer0_underflow, timer1_underflow, lfo_rise} <= 3'h0;
      #1;
   endtask

   task go(input int k);
      ev(k);
      m_cnt = m_rel;
      m_run = 1;
      check({15'h0, timer_running}, 16'h1);
   endtask

   task halt(input int k);
      ev(k);
      m_run = 0;
      check({15'h0, timer_running}, 16'h0);
   endtask

   task tick(input int k, input int hit);
      int uf;
      uf = 0;
      if (hit != 0 && m_run != 0) begin
         if (m_cnt == 0) begin
            if (m_nouf == 0) begin
               uf = 1;
               if (m_auto != 0) m_cnt = m_rel;
               else m_run = 0;
            end
         end else begin
            m_cnt = m_cnt - 1;
         end
      end
      ev(k);
      check({15'h0, timer_underflow_request}, 16'(uf));
      check({15'h0, timer_running}, 16'(m_run));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn, reg_wr, reg_rd, tx_end, rx_first_nibble, start_now, stop_now} = 7'h00;
      {timer0_underflow, timer1_underflow, lfo_rise} = 3'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      second_timer_count = 16'h0000;
      seed = 32'hE127;
      {n_fail, check_count, cycles, m_cnt, m_rel, m_auto, m_run, m_nouf} = '0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(ADDR_CONTROL, 8'h00);
      rd_chk(ADDR_RELOAD_HIGH, 8'h00);
      chk_cnt();
      wr(ADDR_CONTROL, 8'hFF);
      rd_chk(ADDR_CONTROL, 8'hBB);
      wr(8'h40, 8'h55);
      rd_chk(8'h40, 8'h00);
      rd_chk(ADDR_CONTROL, 8'hBB);
      for (int i = 0; i < 3; i++) begin
         v = xs();
         second_timer_count <= v[15:0];
         rd_chk(ADDR_T2_COUNT_LOW, v[7:0]);
      end
      // Full reload word lands in counter
      wr(ADDR_CONTROL, 8'h02);
      v = xs();
      wr(ADDR_RELOAD_HIGH, v[15:8]);
      wr(ADDR_RELOAD_LOW, v[7:0]);
      rd_chk(ADDR_RELOAD_HIGH, v[15:8]);
      rd_chk(ADDR_RELOAD_LOW, v[7:0]);
      m_rel = int'(v[15:0]);
      go(0);
      chk_cnt();
      halt(1);
      // One-shot count on timer0 underflows
      wr(ADDR_RELOAD_HIGH, 8'h00);
      m_rel = int'(xs() & 32'h3) + 1;
      wr(ADDR_RELOAD_LOW, 8'(m_rel));
      go(0);
      tick(5, 0);
      for (int i = 0; i < m_rel + 2; i++) begin
         tick(4, 1);
         chk_cnt();
      end
      rd_chk(ADDR_IRQ_STATUS, 8'h01);
      check({15'h0, irq}, 16'h0);
      wr(ADDR_IRQ_MASK, 8'h01);
      rd_chk(ADDR_IRQ_STATUS, 8'h01);
      check({15'h0, irq}, 16'h1);
      wr(ADDR_IRQ_STATUS, 8'h01);
      rd_chk(ADDR_IRQ_STATUS, 8'h00);
      check({15'h0, irq}, 16'h0);
      // Auto reload on timer1, reload write mid-run
      wr(ADDR_CONTROL, 8'h0B);
      m_auto = 1;
      go(0);
      m_new = 2 * m_rel + 3;
      for (int i = 0; i < m_new; i++) begin
         // Running count kept, next reload uses new byte
         if (i == 1) begin
            wr(ADDR_RELOAD_LOW, 8'h07);
            m_rel = 7;
         end
         tick(5, 1);
         chk_cnt();
      end
      halt(1);
      m_rel = 7;
      go(0);
      chk_cnt();
      halt(1);
      // Start after transmit and receive halt
      m_auto = 0;
      wr(ADDR_CONTROL, 8'h02);
      ev(2);
      check({15'h0, timer_running}, 16'h0);
      wr(ADDR_CONTROL, 8'h92);
      go(2);
      chk_cnt();
      halt(3);
      wr(ADDR_CONTROL, 8'h12);
      go(2);
      ev(3);
      check({15'h0, timer_running}, 16'h1);
      halt(1);
      // Trimming without underflow, receive halt ignored
      wr(ADDR_RELOAD_LOW, 8'h00);
      m_rel = 0;
      wr(ADDR_CONTROL, 8'hA2);
      ev(0);
      check({15'h0, timer_running}, 16'h0);
      rd_chk(ADDR_RUN_STATE, 8'h02);
      go(6);
      m_nouf = 1;
      tick(4, 1);
      chk_cnt();
      ev(3);
      check({15'h0, timer_running}, 16'h1);
      halt(6);
      rd(ADDR_IRQ_STATUS, d);
      check({15'h0, d[2]}, 16'h1);
      check({15'h0, d[1]}, 16'h1);
      // Trimming with underflow
      m_nouf = 0;
      m_auto = 1;
      wr(ADDR_CONTROL, 8'h3A);
      ev(0);
      go(6);
      tick(4, 1);
      halt(6);
      // Carrier and divided carrier rates
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_RELOAD_HIGH, 8'h10);
      go(0);
      repeat (100) @(posedge clk);
      rd(ADDR_COUNT_LOW, d);
      check({15'h0, (d >= 8'hE2) && (d <= 8'hE7)}, 16'h1);
      halt(1);
      wr(ADDR_CONTROL, 8'h01);
      wr(ADDR_RELOAD_HIGH, 8'h00);
      wr(ADDR_RELOAD_LOW, 8'h10);
      go(0);
      repeat (1000) @(posedge clk);
      rd(ADDR_COUNT_LOW, d);
      check({15'h0, (d >= 8'h0B) && (d <= 8'h0D)}, 16'h1);
      halt(1);
      print_verdict();
   end
endmodule
